// file: src/spi_flags_pkg.sv
`default_nettype none
package spi_flags_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_DATA_WINDOW = 4'h0;
  localparam logic [3:0] ADDR_STAT_CTRL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_ENTRY_COUNT = 4'h4;

  // ---------------------------------------------------------------------------
  // Field positions of serial_status_control
  // ---------------------------------------------------------------------------
  localparam int unsigned BIT_RBF = 0;
  localparam int unsigned BIT_TBF = 1;
  localparam int unsigned BIT_ENH = 2;
  localparam int unsigned BIT_EN = 15;

  // ---------------------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------------------
  localparam int unsigned IRQ_TX_FULL = 0;
  localparam int unsigned IRQ_RX_FULL = 1;
  localparam int unsigned IRQ_TX_DROP = 2;
  localparam int unsigned IRQ_RX_OVF = 3;
  localparam int unsigned IRQ_W = 4;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_ENH_MODE = 1'b0;

  localparam int unsigned DEF_DEPTH = 4;
  localparam int unsigned DEF_WIDTH = 16;

endpackage
`default_nettype wire

// file: src/tx_entry_store.sv
`timescale 1ns/100ps
`default_nettype none
module tx_entry_store
  import spi_flags_pkg::*;
#(
  parameter int unsigned WIDTH = DEF_WIDTH,
  parameter int unsigned DEPTH = DEF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic [$clog2(DEPTH+1)-1:0] limit_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o,
  output logic empty_o,
  output logic full_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  // Limit lets one store serve both the single holding word and the multi-entry mode.
  assign full_o = (cnt_q >= limit_i);
  assign empty_o = (cnt_q == '0);
  // A push beside a pop of a full store is taken, since the pop frees its entry at the same edge.
  assign do_push = push_i && (!full_o || do_pop);
  assign do_pop = pop_i && !empty_o;
  assign head_o = mem_q[rd_q];
  assign count_o = cnt_q;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule
`default_nettype wire

// file: src/irq_sticky.sv
`timescale 1ns/100ps
`default_nettype none
module irq_sticky
  import spi_flags_pkg::*;
#(
  parameter int unsigned W = IRQ_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] event_i,
  input wire logic [W-1:0] clear_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_wdata_i,
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);
  logic [W-1:0] status_q;
  logic [W-1:0] mask_q;

  // A new event in the clearing cycle wins, so no event is lost.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_i) | event_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= RST_IRQ_MASK;
    end else if (mask_we_i) begin
      mask_q <= mask_wdata_i;
    end
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = |(status_q & mask_q);
endmodule
`default_nettype wire

// file: src/spi_buffer_status_flags.sv
// Overview of operation
// - In single-buffer mode a processor write of the data window loads the holding word and sets the tx-full flag.
// - In single-buffer mode the tx-full flag clears when the held word moves into the shift register stage.
// - In multi-entry mode the tx-full flag sets only when a write fills the last free transmit entry.
// - In multi-entry mode the tx-full flag clears as soon as any transmit entry is free again.
// - In single-buffer mode the rx-full flag sets when a finished word moves from the shift stage to the holding word.
// - In single-buffer mode the rx-full flag clears when the processor reads the data window.
// - In multi-entry mode the rx-full flag sets only when an arriving word fills the last unread entry.
// - In multi-entry mode the rx-full flag clears once an entry is free to take another word.
`timescale 1ns/100ps
`default_nettype none
module spi_buffer_status_flags
  import spi_flags_pkg::*;
#(
  parameter int unsigned WIDTH = DEF_WIDTH,
  parameter int unsigned DEPTH = DEF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic shift_load_ready_i,
  output logic shift_load_valid_o,
  output logic [WIDTH-1:0] shift_load_data_o,
  input wire logic shift_done_i,
  input wire logic [WIDTH-1:0] shift_rx_data_i,
  output logic module_enable_bit_o,
  output logic tx_buffer_full_flag_o,
  output logic rx_buffer_full_flag_o,
  output logic irq_o
);
  localparam int unsigned CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] ONE_ENTRY = CW'(1);
  localparam logic [CW-1:0] ALL_ENTRIES = CW'(DEPTH);

  // ---------------------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------------------
  logic enable_q;
  logic enh_mode_q;
  logic [CW-1:0] limit;
  logic [15:0] rdata_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q <= RST_ENABLE;
      enh_mode_q <= RST_ENH_MODE;
    end else if (wr_i && addr_i == ADDR_STAT_CTRL) begin
      enable_q <= wdata_i[BIT_EN];
      enh_mode_q <= wdata_i[BIT_ENH];
    end
  end

  // Single-buffer mode is the same store with room for only one word.
  assign limit = enh_mode_q ? ALL_ENTRIES : ONE_ENTRY;

  // ---------------------------------------------------------------------------
  // Data window decode
  // ---------------------------------------------------------------------------
  logic tx_push;
  logic rx_pop;
  logic flush;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic [WIDTH-1:0] tx_head;
  logic [WIDTH-1:0] rx_head;
  logic [CW-1:0] tx_count;
  logic [CW-1:0] rx_count;
  logic tx_pop;
  logic rx_push;

  assign tx_push = wr_i && addr_i == ADDR_DATA_WINDOW && enable_q;
  assign rx_pop = rd_i && addr_i == ADDR_DATA_WINDOW;
  // Disabling the module or switching mode drops buffered words so counts stay coherent.
  assign flush = !enable_q || (wr_i && addr_i == ADDR_STAT_CTRL && wdata_i[BIT_ENH] != enh_mode_q);

  assign shift_load_valid_o = !tx_empty && enable_q;
  assign shift_load_data_o = tx_head;
  assign tx_pop = shift_load_valid_o && shift_load_ready_i;
  assign rx_push = shift_done_i && enable_q;

  tx_entry_store #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_tx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .limit_i(limit),
    .push_i(tx_push),
    .push_data_i(wdata_i[WIDTH-1:0]),
    .pop_i(tx_pop),
    .head_o(tx_head),
    .count_o(tx_count),
    .empty_o(tx_empty),
    .full_o(tx_full)
  );

  tx_entry_store #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .limit_i(limit),
    .push_i(rx_push),
    .push_data_i(shift_rx_data_i),
    .pop_i(rx_pop),
    .head_o(rx_head),
    .count_o(rx_count),
    .empty_o(rx_empty),
    .full_o(rx_full)
  );

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  // Flags follow the stored count: set when the last free entry fills, clear when one frees.
  assign tx_buffer_full_flag_o = tx_full;
  assign rx_buffer_full_flag_o = rx_full;
  assign module_enable_bit_o = enable_q;

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic tx_full_d1_q;
  logic rx_full_d1_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_full_d1_q <= 1'b0;
      rx_full_d1_q <= 1'b0;
    end else begin
      tx_full_d1_q <= tx_full;
      rx_full_d1_q <= rx_full;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_TX_FULL] = tx_full && !tx_full_d1_q;
    irq_event[IRQ_RX_FULL] = rx_full && !rx_full_d1_q;
    irq_event[IRQ_TX_DROP] = wr_i && addr_i == ADDR_DATA_WINDOW && ((tx_full && !tx_pop) || !enable_q);
    irq_event[IRQ_RX_OVF] = rx_push && rx_full && !rx_pop;
  end

  assign irq_clear = (wr_i && addr_i == ADDR_IRQ_STATUS) ? wdata_i[IRQ_W-1:0] : '0;

  irq_sticky #(
    .W(IRQ_W)
  ) u_irq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .event_i(irq_event),
    .clear_i(irq_clear),
    .mask_we_i(wr_i && addr_i == ADDR_IRQ_MASK),
    .mask_wdata_i(wdata_i[IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  // A received word arriving while the store is full, with no read at that edge, is dropped and reported.
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (addr_i)
      ADDR_DATA_WINDOW: rd_mux[WIDTH-1:0] = rx_empty ? '0 : rx_head;
      ADDR_STAT_CTRL: begin
        rd_mux[BIT_EN] = enable_q;
        rd_mux[BIT_ENH] = enh_mode_q;
        rd_mux[BIT_TBF] = tx_full;
        rd_mux[BIT_RBF] = rx_full;
      end
      ADDR_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
      ADDR_ENTRY_COUNT: rd_mux = {8'(rx_count), 8'(tx_count)};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= RST_DATA;
    end else if (rd_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= RST_DATA;
    end
  end

  assign rdata_o = rdata_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence single_load_s;
    !enh_mode_q && tx_push && tx_empty && !flush;
  endsequence

  sequence single_move_s;
    !enh_mode_q && tx_pop && !tx_push && !flush;
  endsequence

  tx_single_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    single_load_s |=> tx_buffer_full_flag_o)
    else $error("tx full not set after single-buffer load");

  tx_single_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    single_move_s |=> !tx_buffer_full_flag_o)
    else $error("tx full not cleared after move to shift stage");

  tx_multi_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enh_mode_q && !flush && $rose(tx_buffer_full_flag_o)) |-> $past(tx_count) == ALL_ENTRIES - 1'b1)
    else $error("tx full rose before last entry filled");

  tx_multi_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enh_mode_q && tx_full && tx_pop && !tx_push && !flush) |=> !tx_buffer_full_flag_o)
    else $error("tx full held with a free entry");

  rx_single_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enh_mode_q && rx_push && rx_empty && !flush) |=> rx_buffer_full_flag_o)
    else $error("rx full not set after word arrived");

  rx_single_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enh_mode_q && rx_pop && !rx_push && !flush) |=> !rx_buffer_full_flag_o)
    else $error("rx full not cleared by data read");

  rx_multi_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enh_mode_q && rx_count == ALL_ENTRIES - 1'b1 && rx_push && !rx_pop && !flush) |=> rx_buffer_full_flag_o)
    else $error("rx full not set when last entry filled");

  rx_multi_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enh_mode_q && rx_full && rx_pop && !rx_push && !flush) |=> !rx_buffer_full_flag_o)
    else $error("rx full held with a free entry");

  window_decode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == ADDR_DATA_WINDOW && enable_q && !tx_full && !tx_pop && !flush)
    |=> tx_count == $past(tx_count) + 1'b1)
    else $error("data window write did not load transmit path");

  // ---------------------------------------------------------------------------
  // Interface and event checks
  // ---------------------------------------------------------------------------
  sequence tx_drop_s;
    wr_i && addr_i == ADDR_DATA_WINDOW && tx_full && !tx_pop;
  endsequence

  // The swap is the one edge at which a full store both gives and takes a word.
  sequence rx_swap_s;
    rx_push && rx_full && rx_pop && !flush;
  endsequence

  rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside the read answer");

  rdata_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == ADDR_DATA_WINDOW && !rx_empty) |=> rdata_o[WIDTH-1:0] == $past(rx_head))
    else $error("data window read did not return the oldest word");

  rdata_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == ADDR_STAT_CTRL)
    |=> rdata_o[BIT_TBF] == $past(tx_full) && rdata_o[BIT_RBF] == $past(rx_full))
    else $error("status read did not show the full flags");

  tx_drop_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_drop_s |=> irq_status[IRQ_TX_DROP])
    else $error("refused transmit write not reported");

  tx_drop_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_drop_s ##0 enable_q) |=> tx_count == $past(tx_count))
    else $error("refused transmit write changed the entry count");

  tx_pop_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tx_pop && !tx_push && !flush) |=> tx_count == $past(tx_count) - 1'b1)
    else $error("move to shift stage did not free an entry");

  tx_flag_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enh_mode_q && tx_buffer_full_flag_o) |-> tx_count == ONE_ENTRY)
    else $error("tx full flag without one held word");

  tx_flag_multi_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enh_mode_q && tx_buffer_full_flag_o) |-> tx_count == ALL_ENTRIES)
    else $error("tx full flag with a free entry");

  rx_flag_single_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enh_mode_q && rx_buffer_full_flag_o) |-> rx_count == ONE_ENTRY)
    else $error("rx full flag without one held word");

  rx_flag_multi_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (enh_mode_q && rx_buffer_full_flag_o) |-> rx_count == ALL_ENTRIES)
    else $error("rx full flag with an unread entry free");

  rx_read_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_pop && !rx_empty && !rx_push && !flush) |=> rx_count == $past(rx_count) - 1'b1)
    else $error("data window read did not free an entry");

  rx_swap_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_swap_s |=> rx_buffer_full_flag_o)
    else $error("rx full dropped although the store refilled");

  rx_swap_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_swap_s |=> !irq_status[IRQ_RX_OVF] || $past(irq_status[IRQ_RX_OVF]))
    else $error("overflow reported for a word that was taken");

  rx_ovf_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rx_push && rx_full && !rx_pop) |=> irq_status[IRQ_RX_OVF])
    else $error("dropped received word not reported");

  tx_full_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(tx_buffer_full_flag_o) |=> irq_status[IRQ_TX_FULL])
    else $error("tx full rise not reported");

  rx_full_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rx_buffer_full_flag_o) |=> irq_status[IRQ_RX_FULL])
    else $error("rx full rise not reported");

  disable_flush_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !enable_q |=> tx_count == '0 && rx_count == '0)
    else $error("disabled module kept buffered words");

  disabled_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enable_q && wr_i && addr_i == ADDR_DATA_WINDOW) |=> irq_status[IRQ_TX_DROP])
    else $error("write to a disabled module not reported");
endmodule
`default_nettype wire

// file: testbench/shift_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module shift_stage_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic send_i,
  input wire logic [15:0] word_i,
  output logic ready_o,
  output logic done_o,
  output logic [15:0] rx_o
);
  // The stage stalls on command so that the holding entries can be seen full.
  assign ready_o = !stall_i;

  // Outside the done pulse the word toggles, so a stale value never passes for data.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      rx_o <= 16'h0000;
    end else begin
      done_o <= send_i;
      rx_o <= send_i ? word_i : ~rx_o;
    end
  end
endmodule
`default_nettype wire

// file: testbench/spi_buffer_status_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spi_buffer_status_flags_tb;
  import spi_flags_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic ready;
  logic valid;
  logic [15:0] load_data;
  logic done;
  logic [15:0] rx_word;
  logic enable;
  logic tbf;
  logic rbf;
  logic irq_o;
  logic stall = 1'b1;
  logic send = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [15:0] v;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;

  always #50 clk_i = ~clk_i;

  spi_buffer_status_flags #(.WIDTH(16), .DEPTH(4)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .shift_load_ready_i(ready), .shift_load_valid_o(valid), .shift_load_data_o(load_data),
    .shift_done_i(done), .shift_rx_data_i(rx_word), .module_enable_bit_o(enable),
    .tx_buffer_full_flag_o(tbf), .rx_buffer_full_flag_o(rbf), .irq_o(irq_o));

  shift_stage_model model_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .send_i(send), .word_i(word),
    .ready_o(ready), .done_o(done), .rx_o(rx_word));

  // ---------------------------------------------------------------------------
  // Bus cycles and comparisons
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // The stage is released for exactly one edge, so exactly one word leaves.
  task automatic pop1;
    @(posedge clk_i);
    stall <= 1'b0;
    @(posedge clk_i);
    stall <= 1'b1;
    #1;
  endtask

  task automatic push(input logic [15:0] w);
    @(posedge clk_i);
    send <= 1'b1;
    word <= w;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic s_reset;
    chk1(tbf, 1'b0);
    chk1(rbf, 1'b0);
    rd(ADDR_STAT_CTRL, v);
    chk(v, 16'h0000);
    rd(ADDR_IRQ_MASK, v);
    chk(v, 16'h0000);
    rd(4'hf, v);
    chk(v, 16'h0000);
  endtask

  task automatic s_single_tx;
    // The link is taken as set up before the enable bit is written.
    wr(ADDR_STAT_CTRL, 16'h8000);
    chk1(enable, 1'b1);
    wr(ADDR_DATA_WINDOW, 16'h1234);
    chk1(tbf, 1'b1);
    chk(load_data, 16'h1234);
    rd(ADDR_STAT_CTRL, v);
    chk(v, 16'h8002);
    wr(ADDR_DATA_WINDOW, 16'h5678);
    chk(load_data, 16'h1234);
    rd(ADDR_IRQ_STATUS, v);
    chk1(v[IRQ_TX_DROP], 1'b1);
    pop1;
    chk1(tbf, 1'b0);
    chk1(valid, 1'b0);
  endtask

  task automatic s_single_rx;
    push(16'habcd);
    chk1(rbf, 1'b1);
    rd(ADDR_STAT_CTRL, v);
    chk(v, 16'h8001);
    push(16'h1111);
    rd(ADDR_DATA_WINDOW, v);
    chk(v, 16'habcd);
    chk1(rbf, 1'b0);
    rd(ADDR_IRQ_STATUS, v);
    chk1(v[IRQ_RX_OVF], 1'b1);
  endtask

  task automatic s_multi;
    wr(ADDR_STAT_CTRL, 16'h8004);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DATA_WINDOW, 16'h0a00 + 16'(i));
      chk1(tbf, i == 3);
    end
    chk(load_data, 16'h0a00);
    pop1;
    chk1(tbf, 1'b0);
    chk(load_data, 16'h0a01);
    for (int i = 0; i < 4; i++) begin
      push(16'h0b00 + 16'(i));
      chk1(rbf, i == 3);
    end
    rd(ADDR_ENTRY_COUNT, v);
    chk(v, 16'h0403);
    rd(ADDR_DATA_WINDOW, v);
    chk(v, 16'h0b00);
    chk1(rbf, 1'b0);
  endtask

  task automatic s_irq;
    wr(ADDR_IRQ_STATUS, 16'h000f);
    rd(ADDR_IRQ_STATUS, v);
    chk(v, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0001);
    chk1(irq_o, 1'b0);
    wr(ADDR_DATA_WINDOW, 16'h0a04);
    rd(ADDR_IRQ_STATUS, v);
    chk1(v[IRQ_TX_FULL], 1'b1);
    chk1(irq_o, 1'b1);
    wr(ADDR_IRQ_MASK, 16'h0000);
    chk1(irq_o, 1'b0);
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_IRQ_STATUS, 16'h0001);
    chk1(irq_o, 1'b0);
  endtask

  // A read and an arriving word meet at one edge while the receive store is full.
  task automatic s_swap;
    push(16'h0b04);
    chk1(rbf, 1'b1);
    @(posedge clk_i);
    send <= 1'b1;
    word <= 16'h0c00;
    @(posedge clk_i);
    send <= 1'b0;
    addr_i <= ADDR_DATA_WINDOW;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, 16'h0b01);
    chk1(rbf, 1'b1);
    rd(ADDR_IRQ_STATUS, v);
    chk1(v[IRQ_RX_OVF], 1'b0);
    rd(ADDR_ENTRY_COUNT, v);
    chk(v, 16'h0404);
  endtask

  task automatic s_disable;
    wr(ADDR_STAT_CTRL, 16'h0000);
    chk1(enable, 1'b0);
    rd(ADDR_ENTRY_COUNT, v);
    chk(v, 16'h0000);
    chk1(tbf, 1'b0);
    chk1(rbf, 1'b0);
    chk1(valid, 1'b0);
    wr(ADDR_IRQ_STATUS, 16'h0004);
    wr(ADDR_DATA_WINDOW, 16'h2222);
    rd(ADDR_IRQ_STATUS, v);
    chk1(v[IRQ_TX_DROP], 1'b1);
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A healthy run ends in about a hundred cycles; this ceiling cuts a hang.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      results;
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_reset;
    s_single_tx;
    s_single_rx;
    s_multi;
    s_irq;
    s_swap;
    s_disable;
    results;
  end
endmodule
`default_nettype wire
